//--- hw/rx_pcomp_dev.sv
// transceiver end: per channel phase compensation fifo and read clock pick
// assumes ticks on the user side mark edges of the pcs and core clocks
//
// Behaviour
// - fifo written by pcs clock, read by fabric clock
// - fabric read clock has zero frequency offset
// - identical channels share clock sources and configuration
// - rate matcher: group reads lowest channel tx clock
// - fabric captures group data with leader tx clock
// - no rate matcher: own recovered clock, driven out
// - fabric captures with channel's own recovered clock
// - bonded configurations always include rate matcher
// - bonded reads core clock, x8 from master
// - fabric captures bonded data with core clock
// - external read clock input overrides automatic pick
// - shared external driver matches all write clocks
// - fabric captures with the shared external driver
// - direct pma: own transmit parallel clock
// - direct pma may share central channel clock
// - no core clock out in direct pma
// - read clock never differs in frequency
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rx_pcomp_dev
  import rx_pcomp_pkg::*;
#(
  parameter int NCH   = rx_pcomp_pkg::NCH_DEF,
  parameter int W     = rx_pcomp_pkg::DATA_W_DEF,
  parameter int DEPTH = rx_pcomp_pkg::DEPTH_DEF,
  parameter int SIG_W = rx_pcomp_pkg::SIG_W_DEF
) (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  rx_pcomp_if.dev                           link,
  input  wire logic [NCH-1:0]               wr_tick,
  input  wire logic [NCH-1:0][W-1:0]        wr_data,
  input  wire logic [NCH-1:0]               tx_par_tick,
  input  wire logic [NCH-1:0]               rec_par_tick,
  input  wire logic                         core_tick,
  input  wire logic                         master_core_tick,
  input  wire rx_pcomp_pkg::mode_t          mode_cfg,
  input  wire logic [NCH-1:0][SIG_W-1:0]    chan_sig
);
  import rx_pcomp_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int PW = AW + 1;
  localparam int LW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] ONE_P   = PW'(1);

  typedef struct packed {
    logic [NCH-1:0][DEPTH-1:0][W-1:0] mem;
    logic [NCH-1:0][PW-1:0]           wbin;
    logic [NCH-1:0][PW-1:0]           rbin;
    logic [NCH-1:0][PW-1:0]           wgray;
    logic [NCH-1:0][PW-1:0]           rgray;
    logic [NCH-1:0][PW-1:0]           wg_s1;
    logic [NCH-1:0][PW-1:0]           wg_s2;
    logic [NCH-1:0][PW-1:0]           rg_s1;
    logic [NCH-1:0][PW-1:0]           rg_s2;
    logic [NCH-1:0][W-1:0]            data;
    logic [NCH-1:0]                   valid;
    logic [NCH-1:0]                   ovf;
    logic [NCH-1:0]                   unf;
    src_t [NCH-1:0]                   src;
    logic [NCH-1:0][LW-1:0]           leader;
    mode_t                            mode;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [PW-1:0] b2g(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  logic [NCH-1:0] rd_tick;
  logic           bonded;

  assign bonded = (s_r.mode == MODE_X4) || (s_r.mode == MODE_X8);

  always_comb begin
    logic [LW-1:0] ld;
    logic [PW-1:0] wsync;
    logic [PW-1:0] rsync;
    logic [PW-1:0] wb;
    logic [PW-1:0] rb;
    ld    = '0;
    wsync = '0;
    rsync = '0;
    wb    = '0;
    rb    = '0;
    s_nxt = s_r;
    s_nxt.mode  = mode_cfg;
    s_nxt.valid = '0;
    s_nxt.ovf   = '0;
    s_nxt.unf   = '0;
    rd_tick     = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      // lowest channel with an identical signature leads the group
      ld = LW'(ch);
      for (int j = NCH - 1; j >= 0; j--) begin
        if (j <= ch && chan_sig[j] == chan_sig[ch]) begin
          ld = LW'(j);
        end
      end
      s_nxt.leader[ch] = ld;

      if (link.ext_en[ch]) begin
        s_nxt.src[ch] = SRC_EXT;
        rd_tick[ch]   = link.ext_tick[ch];
      end else begin
        case (s_r.mode)
          MODE_NB_RM: begin
            s_nxt.src[ch] = SRC_TX_LEADER;
            rd_tick[ch]   = tx_par_tick[s_r.leader[ch]];
          end
          MODE_NB_NORM: begin
            s_nxt.src[ch] = SRC_REC_OWN;
            rd_tick[ch]   = rec_par_tick[ch];
          end
          MODE_X4: begin
            s_nxt.src[ch] = SRC_CORE;
            rd_tick[ch]   = core_tick;
          end
          MODE_X8: begin
            s_nxt.src[ch] = SRC_MASTER_CORE;
            rd_tick[ch]   = master_core_tick;
          end
          default: begin
            s_nxt.src[ch] = SRC_TX_OWN;
            rd_tick[ch]   = tx_par_tick[ch];
          end
        endcase
      end

      // pointers cross through two stages; the second alone is looked at
      s_nxt.wg_s1[ch] = s_r.wgray[ch];
      s_nxt.wg_s2[ch] = s_r.wg_s1[ch];
      s_nxt.rg_s1[ch] = s_r.rgray[ch];
      s_nxt.rg_s2[ch] = s_r.rg_s1[ch];
      rsync = g2b(s_r.rg_s2[ch]);
      wsync = g2b(s_r.wg_s2[ch]);

      // write side, paced by the pcs parallel clock
      if (wr_tick[ch]) begin
        if ((s_r.wbin[ch] - rsync) == DEPTH_P) begin
          s_nxt.ovf[ch] = 1'b1;
        end else begin
          s_nxt.mem[ch][s_r.wbin[ch][AW-1:0]] = wr_data[ch];
          wb = s_r.wbin[ch] + ONE_P;
          s_nxt.wbin[ch]  = wb;
          s_nxt.wgray[ch] = b2g(wb);
        end
      end

      // read side, paced by the selected fabric clock
      if (rd_tick[ch]) begin
        if (s_r.rbin[ch] == wsync) begin
          s_nxt.unf[ch] = 1'b1;
        end else begin
          s_nxt.data[ch]  = s_r.mem[ch][s_r.rbin[ch][AW-1:0]];
          s_nxt.valid[ch] = 1'b1;
          rb = s_r.rbin[ch] + ONE_P;
          s_nxt.rbin[ch]  = rb;
          s_nxt.rgray[ch] = b2g(rb);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.rx_data       = s_r.data;
  assign link.rx_valid      = s_r.valid;
  assign link.ovf           = s_r.ovf;
  assign link.unf           = s_r.unf;
  assign link.rd_src        = s_r.src;
  assign link.leader        = s_r.leader;
  assign link.mode          = s_r.mode;
  // bonded links always carry the rate matcher
  assign link.rate_match_on = bonded || (s_r.mode == MODE_NB_RM);
  assign link.rec_clk_out   = rec_par_tick;
  assign link.tx_clk_out    = tx_par_tick;
  // core clock only leaves in bonded modes, never in direct pma
  assign link.core_clk_out  = (s_r.mode == MODE_X4) ? core_tick :
                              (s_r.mode == MODE_X8) ? master_core_tick :
                              1'b0;

endmodule

//--- hw/rx_pcomp_fab.sv
// fabric end: captures receive data on the matching clock, drives the
// optional external read clock, and reports through avalon-mm registers
// assumes the external read clock is derived from a transmit clock tick
`timescale 1ns/1ps
module rx_pcomp_fab
  import rx_pcomp_pkg::*;
#(
  parameter int NCH = rx_pcomp_pkg::NCH_DEF,
  parameter int W   = rx_pcomp_pkg::DATA_W_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  rx_pcomp_if.fab                    link,
  input  wire logic [1:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output logic [NCH-1:0][W-1:0]      cap_data,
  output logic [NCH-1:0]             cap_valid
);
  import rx_pcomp_pkg::*;

  localparam int LW = (NCH > 1) ? $clog2(NCH) : 1;

  typedef struct packed {
    logic [NCH-1:0]        ext;
    logic [LW-1:0]         src;
    logic [NCH-1:0]        mism;
    logic [NCH-1:0]        ovf;
    logic [NCH-1:0]        unf;
    logic [NCH-1:0]        exp_d;
    logic [NCH-1:0][W-1:0] data;
    logic [NCH-1:0]        valid;
    logic                  ack;
    logic [31:0]           rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic           req;
  logic           common_tick;
  logic [NCH-1:0] exp_tick;

  assign req = avs_read || avs_write;
  // shared driver is a transmit clock, so it has no offset to any writer
  assign common_tick = link.tx_clk_out[s_r.src];

  always_comb begin
    logic [31:0] rd;
    logic [NCH-1:0] clr;
    rd    = '0;
    clr   = '0;
    s_nxt = s_r;
    s_nxt.valid = '0;
    exp_tick    = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      if (s_r.ext[ch]) begin
        exp_tick[ch] = common_tick;
      end else begin
        case (link.mode)
          MODE_NB_RM:   exp_tick[ch] = link.tx_clk_out[link.leader[ch]];
          MODE_NB_NORM: exp_tick[ch] = link.rec_clk_out[ch];
          MODE_X4:      exp_tick[ch] = link.core_clk_out;
          MODE_X8:      exp_tick[ch] = link.core_clk_out;
          default:      exp_tick[ch] = link.tx_clk_out[ch];
        endcase
      end
    end
    s_nxt.exp_d = exp_tick;

    // register access: one wait state, effect at the accepting edge
    s_nxt.ack = req && !s_r.ack;
    if (avs_address == OFF_CTRL) begin
      rd[CTRL_EXT_LSB +: NCH] = s_r.ext;
      rd[CTRL_SRC_LSB +: LW]  = s_r.src;
    end else if (avs_address == OFF_STATUS) begin
      rd[STAT_MISM_LSB +: NCH] = s_r.mism;
      rd[STAT_OVF_LSB +: NCH]  = s_r.ovf;
      rd[STAT_UNF_LSB +: NCH]  = s_r.unf;
    end else if (avs_address == OFF_MODE) begin
      rd[2:0]         = link.mode;
      rd[MODE_RM_BIT] = link.rate_match_on;
    end else begin
      rd = '0;
    end
    if (avs_read && !s_r.ack) begin
      s_nxt.rdata = rd;
    end
    if (avs_write && s_r.ack) begin
      if (avs_address == OFF_CTRL) begin
        s_nxt.ext = avs_writedata[CTRL_EXT_LSB +: NCH];
        s_nxt.src = avs_writedata[CTRL_SRC_LSB +: LW];
      end else if (avs_address == OFF_STATUS) begin
        clr = avs_writedata[STAT_MISM_LSB +: NCH];
      end
    end

    // sticky flags: a new event in the clearing cycle survives
    s_nxt.mism = s_r.mism & ~clr;
    s_nxt.ovf  = (s_r.ovf & ~avs_writedata[STAT_OVF_LSB +: NCH]) | link.ovf;
    s_nxt.unf  = (s_r.unf & ~avs_writedata[STAT_UNF_LSB +: NCH]) | link.unf;
    if (!(avs_write && s_r.ack && avs_address == OFF_STATUS)) begin
      s_nxt.ovf = s_r.ovf | link.ovf;
      s_nxt.unf = s_r.unf | link.unf;
    end

    for (int ch = 0; ch < NCH; ch++) begin
      if (link.rx_valid[ch]) begin
        s_nxt.data[ch]  = link.rx_data[ch];
        s_nxt.valid[ch] = 1'b1;
        // data must come out on the clock this end latches with
        if (!s_r.exp_d[ch]) begin
          s_nxt.mism[ch] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.ext_en      = s_r.ext;
  assign link.ext_tick    = s_r.ext & {NCH{common_tick}};
  assign avs_waitrequest  = req && !s_r.ack;
  assign avs_readdata     = s_r.rdata;
  assign cap_data         = s_r.data;
  assign cap_valid        = s_r.valid;

endmodule

//--- hw/rx_pcomp_if.sv
// link between the transceiver receive fifo end and the fabric end
// assumes both ends share clk; clocks of the link appear as tick levels
`timescale 1ns/1ps
interface rx_pcomp_if #(
  parameter int NCH = rx_pcomp_pkg::NCH_DEF,
  parameter int W   = rx_pcomp_pkg::DATA_W_DEF
);
  localparam int LW = (NCH > 1) ? $clog2(NCH) : 1;

  logic [NCH-1:0][W-1:0]     rx_data;
  logic [NCH-1:0]            rx_valid;
  logic [NCH-1:0]            rec_clk_out;
  logic [NCH-1:0]            tx_clk_out;
  logic                      core_clk_out;
  rx_pcomp_pkg::src_t [NCH-1:0] rd_src;
  logic [NCH-1:0][LW-1:0]    leader;
  rx_pcomp_pkg::mode_t       mode;
  logic                      rate_match_on;
  logic [NCH-1:0]            ovf;
  logic [NCH-1:0]            unf;
  logic [NCH-1:0]            ext_en;
  logic [NCH-1:0]            ext_tick;

  modport dev (
    output rx_data, rx_valid, rec_clk_out, tx_clk_out, core_clk_out,
    output rd_src, leader, mode, rate_match_on, ovf, unf,
    input  ext_en, ext_tick
  );

  modport fab (
    input  rx_data, rx_valid, rec_clk_out, tx_clk_out, core_clk_out,
    input  rd_src, leader, mode, rate_match_on, ovf, unf,
    output ext_en, ext_tick
  );
endinterface

//--- hw/rx_pcomp_pkg.sv
// shared constants and types for the receive phase compensation fifo pair
// assumes one system clock; link clocks are modelled as one-cycle ticks
package rx_pcomp_pkg;

  localparam int NCH_DEF   = 4;
  localparam int DATA_W_DEF = 8;
  localparam int DEPTH_DEF = 4;
  localparam int SIG_W_DEF = 8;

  // channel operating configuration
  typedef enum logic [2:0] {
    MODE_NB_RM   = 3'h0,
    MODE_NB_NORM = 3'h1,
    MODE_X4      = 3'h2,
    MODE_X8      = 3'h3,
    MODE_DIRECT  = 3'h4
  } mode_t;

  // which clock reads a channel's fifo
  typedef enum logic [2:0] {
    SRC_TX_LEADER   = 3'h0,
    SRC_REC_OWN     = 3'h1,
    SRC_CORE        = 3'h2,
    SRC_MASTER_CORE = 3'h3,
    SRC_TX_OWN      = 3'h4,
    SRC_EXT         = 3'h5
  } src_t;

  // avalon word addresses of the fabric-side controller
  localparam logic [1:0] OFF_CTRL   = 2'h0;
  localparam logic [1:0] OFF_STATUS = 2'h1;
  localparam logic [1:0] OFF_MODE   = 2'h2;

  // field positions
  localparam int CTRL_EXT_LSB  = 0;
  localparam int CTRL_SRC_LSB  = 8;
  localparam int STAT_MISM_LSB = 0;
  localparam int STAT_OVF_LSB  = 8;
  localparam int STAT_UNF_LSB  = 16;
  localparam int MODE_RM_BIT   = 8;

endpackage

//--- testbench/rx_pcomp_link_sva.sv
// assertions on the link between the receive fifo end and the fabric end
// assumes it sits beside the interface; link clocks are one-cycle ticks
`timescale 1ns/1ps
module rx_pcomp_link_sva
  import rx_pcomp_pkg::*;
#(
  parameter int NCH = 4,
  parameter int LW  = 2
) (
  input logic                         clk,
  input logic                         reset_n,
  input logic [NCH-1:0]               rx_valid,
  input logic [NCH-1:0]               tx_clk_out,
  input logic [NCH-1:0]               rec_clk_out,
  input logic                         core_clk_out,
  input rx_pcomp_pkg::src_t [NCH-1:0] rd_src,
  input logic [NCH-1:0][LW-1:0]       leader,
  input rx_pcomp_pkg::mode_t          mode,
  input logic                         rate_match_on,
  input logic [NCH-1:0]               unf,
  input logic [NCH-1:0]               ext_en,
  input logic [NCH-1:0]               ext_tick
);
  import rx_pcomp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [NCH-1:0] sel_tick;

  function automatic src_t auto_src(input mode_t m);
    case (m)
      MODE_NB_RM:   return SRC_TX_LEADER;
      MODE_NB_NORM: return SRC_REC_OWN;
      MODE_X4:      return SRC_CORE;
      MODE_X8:      return SRC_MASTER_CORE;
      default:      return SRC_TX_OWN;
    endcase
  endfunction

  // tick of the named source, so every pop under a steady source and leader can be tied to its own clock
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      case (rd_src[i])
        SRC_TX_LEADER:             sel_tick[i] = tx_clk_out[leader[i]];
        SRC_REC_OWN:               sel_tick[i] = rec_clk_out[i];
        SRC_CORE, SRC_MASTER_CORE: sel_tick[i] = core_clk_out;
        SRC_EXT:                   sel_tick[i] = ext_tick[i];
        default:                   sel_tick[i] = tx_clk_out[i];
      endcase
    end
  end

  AST_BONDED_RM: assert property (
    mode inside {MODE_X4, MODE_X8} |-> rate_match_on)
    else $error("bonded mode without rate matcher");
  AST_NO_CORE: assert property (
    mode inside {MODE_NB_RM, MODE_NB_NORM, MODE_DIRECT} |-> !core_clk_out)
    else $error("core clock out outside bonded modes");

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    sequence s_auto_pick;
      !ext_en[i] ##1 1'b1;
    endsequence
    sequence s_ext_pick;
      ext_en[i] ##1 1'b1;
    endsequence
    sequence s_steady;
      $stable(rd_src[i]) && $stable(leader[i]);
    endsequence
    AST_AUTO_SRC: assert property (
      s_auto_pick |-> rd_src[i] == auto_src($past(mode)))
      else $error("automatic read source wrong for mode");
    AST_EXT_SRC: assert property (
      s_ext_pick |-> rd_src[i] == SRC_EXT)
      else $error("external read clock not used");
    AST_POP_TICK: assert property (
      rx_valid[i] ##0 s_steady |-> $past(sel_tick[i]))
      else $error("pop without tick of selected clock");
    AST_UNF_TICK: assert property (
      unf[i] ##0 s_steady |-> $past(sel_tick[i]))
      else $error("underrun without tick of selected clock");
    AST_POP_OR_UNF: assert property (!(rx_valid[i] && unf[i]))
      else $error("pop and underrun together");
    AST_EXT_TICK: assert property (
      ext_tick[i] |-> ext_en[i] && (|tx_clk_out))
      else $error("external tick without enable or transmit tick");
    AST_LEADER: assert property (int'(leader[i]) <= i)
      else $error("leader above own channel");
  end
endmodule

//--- testbench/rx_phase_comp_fifo_clocking_tb.sv
// self-checking bench joining the transceiver end and the fabric end
// assumes package defaults: four channels, eight-bit words, depth four
`timescale 1ns/1ps
module rx_phase_comp_fifo_clocking_tb;
  import rx_pcomp_pkg::*;
  typedef struct packed {
    mode_t m; src_t s; logic rm; logic ck; logic mk;
  } row_t;
  logic                  clk, reset_n, core_tick, master_core_tick;
  logic [3:0]            wr_tick, tx_par_tick, rec_par_tick, cap_valid;
  logic [3:0][7:0]       wr_data, chan_sig, cap_data;
  mode_t                 mode_cfg;
  logic [1:0]            avs_address;
  logic                  avs_read, avs_write, avs_waitrequest;
  logic [31:0]           avs_writedata, avs_readdata, rd;
  int                    n_errors, checks_done;
  row_t                  rows [5] = '{
    '{MODE_NB_RM, SRC_TX_LEADER, 1'b1, 1'b0, 1'b0},
    '{MODE_NB_NORM, SRC_REC_OWN, 1'b0, 1'b0, 1'b0},
    '{MODE_X4, SRC_CORE, 1'b1, 1'b1, 1'b0},
    '{MODE_X8, SRC_MASTER_CORE, 1'b1, 1'b0, 1'b1},
    '{MODE_DIRECT, SRC_TX_OWN, 1'b0, 1'b0, 1'b0}};

  rx_pcomp_if lnk ();
  rx_pcomp_dev u_rx_pcomp_dev (.clk(clk), .reset_n(reset_n), .link(lnk),
    .wr_tick(wr_tick), .wr_data(wr_data), .tx_par_tick(tx_par_tick),
    .rec_par_tick(rec_par_tick), .core_tick(core_tick),
    .master_core_tick(master_core_tick), .mode_cfg(mode_cfg),
    .chan_sig(chan_sig));
  rx_pcomp_fab u_rx_pcomp_fab (.clk(clk), .reset_n(reset_n), .link(lnk),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cap_data(cap_data),
    .cap_valid(cap_valid));
  rx_pcomp_link_sva u_rx_pcomp_link_sva (.clk(clk), .reset_n(reset_n),
    .rx_valid(lnk.rx_valid), .tx_clk_out(lnk.tx_clk_out),
    .rec_clk_out(lnk.rec_clk_out), .core_clk_out(lnk.core_clk_out),
    .rd_src(lnk.rd_src), .leader(lnk.leader), .mode(lnk.mode),
    .rate_match_on(lnk.rate_match_on), .unf(lnk.unf),
    .ext_en(lnk.ext_en), .ext_tick(lnk.ext_tick));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // entered just after a rising edge; one idle cycle follows the accept
  task automatic bus(input logic wr, input logic [1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // waitrequest and readdata are read as this edge sampled them
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  // leaders follow the signature pattern: channels 0,1 and 2,3 pair up
  task automatic drive_src(input src_t s, input int ch, input logic v);
    case (s)
      SRC_TX_LEADER:   tx_par_tick[ch & 2] <= v;
      SRC_REC_OWN:     rec_par_tick[ch] <= v;
      SRC_CORE:        core_tick <= v;
      SRC_MASTER_CORE: master_core_tick <= v;
      SRC_TX_OWN:      tx_par_tick[ch] <= v;
      default:         tx_par_tick[3] <= v;
    endcase
  endtask

  // only the expected source ticks, so a wrong pick pops no word, except leader against own transmit tick on channels 0 and 2
  task automatic xfer(input int ch, input logic [7:0] d, input src_t s);
    wr_tick[ch] <= 1'b1;
    wr_data[ch] <= d;
    @(posedge clk);
    wr_tick[ch] <= 1'b0;
    repeat (2) @(posedge clk);
    drive_src(s, ch, 1'b1);
    @(posedge clk);
    drive_src(s, ch, 1'b0);
    @(negedge clk);
    check(lnk.rx_valid[ch], 1'b1);
    check(lnk.rx_data[ch], d);
    @(negedge clk);
    check(cap_valid[ch], 1'b1);
    check(cap_data[ch], d);
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    {wr_tick, tx_par_tick, rec_par_tick, core_tick, master_core_tick} = '0;
    wr_data = '0;
    chan_sig = {8'h5A, 8'h5A, 8'h3C, 8'h3C};
    mode_cfg = MODE_NB_RM;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    // leaders are registered, so they settle one edge after release
    repeat (2) @(negedge clk);
    check(lnk.leader[1], 2'h0);
    check(lnk.leader[3], 2'h2);
    @(posedge clk);
    chan_sig[2] <= 8'h3C;
    repeat (2) @(negedge clk);
    check(lnk.leader[2], 2'h0);
    @(posedge clk);
    chan_sig[2] <= 8'h5A;
    foreach (rows[r]) begin
      mode_cfg <= rows[r].m;
      repeat (3) @(posedge clk);
      core_tick <= 1'b1;
      @(negedge clk);
      check(lnk.core_clk_out, rows[r].ck);
      check(lnk.rate_match_on, rows[r].rm);
      for (int ch = 0; ch < 4; ch++) begin
        check(lnk.rd_src[ch], rows[r].s);
      end
      @(posedge clk);
      core_tick <= 1'b0;
      master_core_tick <= 1'b1;
      @(negedge clk);
      check(lnk.core_clk_out, rows[r].mk);
      @(posedge clk);
      master_core_tick <= 1'b0;
      for (int ch = 0; ch < 4; ch++) begin
        xfer(ch, 8'(8'hA0 + r * 4 + ch), rows[r].s);
      end
      bus(1'b0, OFF_MODE, 32'h0, rd);
      check(rd, {23'h0, rows[r].rm, 5'h0, rows[r].m});
    end
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    check(rd[7:0], 8'h0);
    // channel 2 read by the transmit tick of channel 3 as shared driver
    bus(1'b1, OFF_CTRL, 32'h0000_0304, rd);
    @(negedge clk);
    check(lnk.rd_src[2], SRC_EXT);
    @(posedge clk);
    xfer(2, 8'h5C, SRC_EXT);
    bus(1'b1, 2'h3, 32'hFFFF_FFFF, rd);
    bus(1'b0, 2'h3, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, OFF_CTRL, 32'h0, rd);
    check(rd, 32'h0000_0304);
    bus(1'b1, OFF_CTRL, 32'h0, rd);
    for (int k = 0; k < 5; k++) begin
      wr_tick[3] <= 1'b1;
      wr_data[3] <= 8'(8'h30 + k);
      @(posedge clk);
    end
    wr_tick[3] <= 1'b0;
    @(negedge clk);
    check(lnk.ovf[3], 1'b1);
    repeat (3) @(posedge clk);
    tx_par_tick[3] <= 1'b1;
    // the first pop lands on the edge after the tick rises
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      check(lnk.rx_data[3], 8'(8'h30 + k));
    end
    @(negedge clk);
    check(lnk.unf[3], 1'b1);
    @(posedge clk);
    tx_par_tick[3] <= 1'b0;
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    check({rd[19], rd[11], rd[7:0]}, 10'h300);
    bus(1'b1, OFF_STATUS, 32'hFFFF_FFFF, rd);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    // a word left in flight must be lost to a reset in mid-run
    wr_tick[1] <= 1'b1;
    @(posedge clk);
    wr_tick[1] <= 1'b0;
    reset_n <= 1'b0;
    @(negedge clk);
    check({lnk.rx_valid, lnk.ext_en, 3'(lnk.mode)}, 11'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    tx_par_tick[1] <= 1'b1;
    @(posedge clk);
    tx_par_tick[1] <= 1'b0;
    @(negedge clk);
    check(lnk.unf[1], 1'b1);
    @(posedge clk);
    close_out();
  end
endmodule
